// >>> rtl/adc_conversion_output_control.sv
// Purpose: conversion sequencing and result output of a two-channel converter
// Assumes: control pins are asynchronous; serial clock is a separate domain
// Notes:   only the external-clock serial read is modelled on the link
//
// Notes on behaviour
// - bit 11 pin becomes overrun flag in serial-external
// - unfinished slave read at conversion end: drop, pulse flag
// - serial mode floats data bits twelve to fifteen
// - busy from start until both results latched
// - end-of-conversion pulses low per channel
// - bus driven only with chip select and read low, except the bit 11 flag pin in serial-external
// - chip select gates the external serial clock
// - reset high aborts any conversion in progress
// - power-down lets current conversion finish, blocks starts
// - start falling edge enters hold and converts
// - impulse mode restarts if start still low after acquisition
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_output_control #(
  parameter int unsigned CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES,
  parameter int unsigned ACQ_CYCLES  = adc_ctrl_pkg::ACQ_CYCLES,
  parameter int unsigned OVR_CYCLES  = adc_ctrl_pkg::OVR_CYCLES
) (
  // reference clock and reset
  input  wire logic                                i_ref_clk,
  input  wire logic                                i_reset,
  // conversion control pins
  input  wire logic                                i_conversion_start_n,
  input  wire logic                                i_power_down_input,
  input  wire logic                                i_impulse_mode,
  // interface configuration pins
  input  wire logic                                i_serial_parallel_select,
  input  wire logic                                i_serial_clock_source_select,
  input  wire logic                                i_read_chan_b,
  // read strobes
  input  wire logic                                i_cs_n,
  input  wire logic                                i_rd_n,
  // external serial clock (link domain)
  input  wire logic                                i_sclk_ext,
  // successive-approximation core
  input  wire logic [adc_ctrl_pkg::RESULT_W-1:0]   i_sar_result,
  output logic                                     o_sar_chan_b,
  output logic                                     o_hold,
  // status
  output logic                                     o_busy,
  output logic                                     o_eoc_n,
  // data bus pins
  output logic [adc_ctrl_pkg::RESULT_W-1:0]        o_data,
  output logic [adc_ctrl_pkg::RESULT_W-1:0]        o_data_oe
);

  localparam logic [adc_ctrl_pkg::TIMER_W-1:0] CONV_LAST =
    adc_ctrl_pkg::TIMER_W'(CONV_CYCLES - 1);
  localparam logic [adc_ctrl_pkg::TIMER_W-1:0] ACQ_LAST  =
    adc_ctrl_pkg::TIMER_W'(ACQ_CYCLES - 1);
  localparam logic [adc_ctrl_pkg::TIMER_W-1:0] OVR_LOAD  =
    adc_ctrl_pkg::TIMER_W'(OVR_CYCLES);
  localparam logic [adc_ctrl_pkg::BITCNT_W-1:0] FRAME_END =
    adc_ctrl_pkg::BITCNT_W'(adc_ctrl_pkg::FRAME_BITS);
  localparam logic [adc_ctrl_pkg::BITCNT_W-1:0] BIT_ONE =
    adc_ctrl_pkg::BITCNT_W'(1);

  // ---------------- reference domain ----------------
  logic [adc_ctrl_pkg::PIN_COUNT-1:0] pins_raw;
  logic [adc_ctrl_pkg::PIN_COUNT-1:0] pins_s;
  logic                               conversion_start_n_s;
  logic                               cs_s;
  logic                               rd_s;
  logic                               pd_s;
  logic                               ser_s;
  logic                               ext_s;
  logic                               imp_s;
  logic                               chb_s;
  logic                               conversion_start_n_prev_q;
  logic                               start_fall;
  adc_ctrl_pkg::conv_state_t          state_q;
  logic [adc_ctrl_pkg::TIMER_W-1:0]   timer_q;
  logic                               conv_a_done;
  logic                               conv_b_done;
  logic                               acq_done;
  logic                               busy_q;
  logic                               eoc_n_q;
  adc_ctrl_pkg::result_pair_t         result_q;
  logic                               valid_q;
  logic                               word_tog_q;
  logic [adc_ctrl_pkg::RESULT_W-1:0]  par_data_q;
  logic [adc_ctrl_pkg::TIMER_W-1:0]   ovr_timer_q;
  logic                               ovr_flag_q;
  logic                               reading_s;
  logic                               bus_en;

  // ---------------- link domain ----------------
  logic                                   tog_s;
  logic                                   tog_seen_q;
  logic                                   new_word;
  logic [adc_ctrl_pkg::FRAME_BITS-1:0]    shift_q;
  logic [adc_ctrl_pkg::BITCNT_W-1:0]      bitcnt_q;
  logic                                   sdout_q;
  logic                                   reading_q;

  // gather the asynchronous control pins
  assign pins_raw = {i_read_chan_b, i_impulse_mode, i_serial_clock_source_select,
                     i_serial_parallel_select, i_power_down_input, i_rd_n, i_cs_n,
                     i_conversion_start_n};

  // bring control pins into the reference domain
  pin_sync #(
    .WIDTH     (adc_ctrl_pkg::PIN_COUNT),
    .RESET_VAL (adc_ctrl_pkg::PIN_IDLE)
  ) u_pin_sync (
    .i_clk   (i_ref_clk),
    .i_reset (i_reset),
    .i_async (pins_raw),
    .o_level (pins_s)
  );

  // named views of the synchronised pins
  assign conversion_start_n_s = pins_s[adc_ctrl_pkg::PIN_CONVERSION_START_N];
  assign cs_s    = pins_s[adc_ctrl_pkg::PIN_CS];
  assign rd_s    = pins_s[adc_ctrl_pkg::PIN_RD];
  assign pd_s    = pins_s[adc_ctrl_pkg::PIN_PD];
  assign ser_s   = pins_s[adc_ctrl_pkg::PIN_SER];
  assign ext_s   = pins_s[adc_ctrl_pkg::PIN_EXT];
  assign imp_s   = pins_s[adc_ctrl_pkg::PIN_IMP];
  assign chb_s   = pins_s[adc_ctrl_pkg::PIN_CHB];

  // falling edge of conversion start
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      conversion_start_n_prev_q <= 1'b1;
    end else begin
      conversion_start_n_prev_q <= conversion_start_n_s;
    end
  end
  assign start_fall = conversion_start_n_prev_q & ~conversion_start_n_s;

  // end-of-phase decodes
  assign conv_a_done = (state_q == adc_ctrl_pkg::ST_CONV_A) && (timer_q == CONV_LAST);
  assign conv_b_done = (state_q == adc_ctrl_pkg::ST_CONV_B) && (timer_q == CONV_LAST);
  assign acq_done    = (state_q == adc_ctrl_pkg::ST_ACQ) && (timer_q == ACQ_LAST);

  // conversion sequencer; async reset aborts any conversion
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      timer_q <= '0;
    end else begin
      case (state_q)
        adc_ctrl_pkg::ST_IDLE: begin
          timer_q <= '0;
          if (start_fall && !pd_s) begin
            state_q <= adc_ctrl_pkg::ST_CONV_A;
          end
        end
        adc_ctrl_pkg::ST_CONV_A: begin
          if (conv_a_done) begin
            state_q <= adc_ctrl_pkg::ST_CONV_B;
            timer_q <= '0;
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
        adc_ctrl_pkg::ST_CONV_B: begin
          if (conv_b_done) begin
            state_q <= adc_ctrl_pkg::ST_ACQ;
            timer_q <= '0;
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
        adc_ctrl_pkg::ST_ACQ: begin
          if (acq_done) begin
            timer_q <= '0;
            if (imp_s && !conversion_start_n_s && !pd_s) begin
              state_q <= adc_ctrl_pkg::ST_CONV_A;
            end else begin
              state_q <= adc_ctrl_pkg::ST_IDLE;
            end
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
        default: begin
          state_q <= adc_ctrl_pkg::ST_IDLE;
          timer_q <= '0;
        end
      endcase
    end
  end

  // busy and hold: high from start until the second result is latched
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_q <= 1'b0;
    end else if ((state_q == adc_ctrl_pkg::ST_IDLE) && start_fall && !pd_s) begin
      busy_q <= 1'b1;
    end else if (acq_done && imp_s && !conversion_start_n_s && !pd_s) begin
      busy_q <= 1'b1;
    end else if (conv_b_done) begin
      busy_q <= 1'b0;
    end
  end

  // one-cycle low end-of-conversion strobe per channel
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      eoc_n_q <= 1'b1;
    end else begin
      eoc_n_q <= ~(conv_a_done | conv_b_done);
    end
  end

  // latch results; the toggle announces a new pair to the link side
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      result_q   <= '0;
      valid_q    <= 1'b0;
      word_tog_q <= 1'b0;
    end else begin
      if (conv_a_done) begin
        result_q.chan_a <= i_sar_result;
      end
      if (conv_b_done) begin
        result_q.chan_b <= i_sar_result;
        valid_q         <= 1'b1;
        word_tog_q      <= ~word_tog_q;
      end
    end
  end

  // parallel output word, channel chosen by the select pin
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      par_data_q <= '0;
    end else begin
      par_data_q <= chb_s ? result_q.chan_b : result_q.chan_a;
    end
  end

  // read still in progress on the link, seen in this domain
  pin_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_read_sync (
    .i_clk   (i_ref_clk),
    .i_reset (i_reset),
    .i_async (reading_q),
    .o_level (reading_s)
  );

  // overrun pulse: a slave read unfinished when the next pair lands
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ovr_timer_q <= '0;
      ovr_flag_q  <= 1'b0;
    end else if (conv_b_done && ser_s && ext_s && reading_s) begin
      ovr_timer_q <= OVR_LOAD;
      ovr_flag_q  <= 1'b1;
    end else if (ovr_timer_q != '0) begin
      ovr_timer_q <= ovr_timer_q - 1'b1;
      ovr_flag_q  <= (ovr_timer_q != adc_ctrl_pkg::TIMER_W'(1));
    end else begin
      ovr_flag_q  <= 1'b0;
    end
  end

  // output enable from both strobes once a result exists
  assign bus_en = ~cs_s & ~rd_s & valid_q;

  // pin drivers; serial-external mode uses bit 8 for data and bit 11 for the flag
  always_comb begin
    o_data    = '0;
    o_data_oe = '0;
    if (!ser_s) begin
      o_data    = par_data_q;
      o_data_oe = {adc_ctrl_pkg::RESULT_W{bus_en}};
    end else if (ext_s) begin
      o_data[adc_ctrl_pkg::PAR_BIT_SDOUT]      = sdout_q;
      o_data_oe[adc_ctrl_pkg::PAR_BIT_SDOUT]   = bus_en;
      o_data[adc_ctrl_pkg::PAR_BIT_OVERRUN]    = ovr_flag_q;
      o_data_oe[adc_ctrl_pkg::PAR_BIT_OVERRUN] = 1'b1;
    end
    // upper bits left undriven in serial mode by the default above
  end

  // status outputs
  assign o_busy       = busy_q;
  assign o_hold       = busy_q;
  assign o_eoc_n      = eoc_n_q;
  assign o_sar_chan_b = (state_q == adc_ctrl_pkg::ST_CONV_B);

  // ---------------- link domain logic ----------------

  // new-pair toggle brought onto the serial clock
  pin_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_tog_sync (
    .i_clk   (i_sclk_ext),
    .i_reset (i_reset),
    .i_async (word_tog_q),
    .o_level (tog_s)
  );
  assign new_word = (tog_s != tog_seen_q);

  // shifter: loads a fresh pair, dropping any read left unfinished
  always_ff @(posedge i_sclk_ext or posedge i_reset) begin
    if (i_reset) begin
      tog_seen_q <= 1'b0;
      shift_q    <= '0;
      bitcnt_q   <= '0;
      sdout_q    <= 1'b0;
      reading_q  <= 1'b0;
    end else if (new_word) begin
      tog_seen_q <= tog_s;
      shift_q    <= result_q; // held stable while the toggle crosses
      bitcnt_q   <= '0;
      reading_q  <= 1'b0;
    end else if (!i_cs_n && (bitcnt_q != FRAME_END)) begin
      sdout_q   <= shift_q[adc_ctrl_pkg::FRAME_BITS-1];
      shift_q   <= {shift_q[adc_ctrl_pkg::FRAME_BITS-2:0], 1'b0};
      bitcnt_q  <= bitcnt_q + BIT_ONE;
      reading_q <= (bitcnt_q + BIT_ONE) != FRAME_END;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/adc_ctrl_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: reference clock of 125 MHz; times below are in nanoseconds
// Notes:   cycle counts derive from the times, least times round up
package adc_ctrl_pkg;

  // reference clock
  localparam int unsigned REF_CLK_PERIOD_NS = 8;

  // conversion time of one channel and acquisition interval (plain defaults)
  localparam int unsigned CONV_TIME_NS      = 400;
  localparam int unsigned ACQ_TIME_NS       = 250;
  localparam int unsigned OVR_PULSE_NS      = 160;

  // derived cycle counts, least times rounded up to whole cycles
  localparam int unsigned CONV_CYCLES =
    (CONV_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int unsigned ACQ_CYCLES  =
    (ACQ_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int unsigned OVR_CYCLES  =
    (OVR_PULSE_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

  // widths
  localparam int unsigned RESULT_W   = 16;
  localparam int unsigned FRAME_BITS = 2 * RESULT_W;
  localparam int unsigned BITCNT_W   = 6;
  localparam int unsigned TIMER_W    = 16;

  // pin positions on the parallel bus
  localparam int unsigned PAR_BIT_SDOUT   = 8;
  localparam int unsigned PAR_BIT_OVERRUN = 11;
  localparam int unsigned PAR_UPPER_LO    = 12;

  // index of each synchronised control pin
  localparam int unsigned PIN_CONVERSION_START_N  = 0;
  localparam int unsigned PIN_CS     = 1;
  localparam int unsigned PIN_RD     = 2;
  localparam int unsigned PIN_PD     = 3;
  localparam int unsigned PIN_SER    = 4;
  localparam int unsigned PIN_EXT    = 5;
  localparam int unsigned PIN_IMP    = 6;
  localparam int unsigned PIN_CHB    = 7;
  localparam int unsigned PIN_COUNT  = 8;

  // idle levels of the control pins: the active-low strobes idle high
  localparam logic [7:0] PIN_IDLE = 8'h07;

  // the pair of results of one conversion
  typedef struct packed {
    logic [RESULT_W-1:0] chan_a;
    logic [RESULT_W-1:0] chan_b;
  } result_pair_t;

  // conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_CONV_A = 4'b0010,
    ST_CONV_B = 4'b0100,
    ST_ACQ    = 4'b1000
  } conv_state_t;

endpackage

// >>> rtl/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter, per bit
// Assumes: inputs are asynchronous to i_clk
// Notes:   output moves only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // asynchronous levels in, filtered levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      // three stage flops plus the level flop, stage one feeds stage two only
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          s1_q  <= RESET_VAL[g];
          s2_q  <= RESET_VAL[g];
          s3_q  <= RESET_VAL[g];
          lvl_q <= RESET_VAL[g];
        end else begin
          s1_q <= i_async[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign o_level[g] = lvl_q;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> test/adc_ctrl_checker.sv
// Purpose: port-level checks of the converter control block
// Assumes: all checks run in the reference clock domain
// Notes:   level runs count raw pin cycles to cover synchroniser lag
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker #(
  parameter int unsigned CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES,
  parameter int unsigned OVR_CYCLES  = adc_ctrl_pkg::OVR_CYCLES
) (
  // clock, reset and control pins
  input wire logic                              i_ref_clk,
  input wire logic                              i_reset,
  input wire logic                              i_conversion_start_n,
  input wire logic                              i_power_down_input,
  input wire logic                              i_serial_parallel_select,
  input wire logic                              i_serial_clock_source_select,
  input wire logic                              i_cs_n,
  input wire logic                              i_rd_n,
  // watched outputs
  input wire logic                              o_hold,
  input wire logic                              o_busy,
  input wire logic                              o_eoc_n,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] o_data,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] o_data_oe
);
  logic [7:0] busy_q;
  logic [7:0] ovr_q;
  logic [3:0] off_q;
  logic [3:0] ser_q;
  logic [3:0] pd_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  function automatic logic [3:0] run(input logic c, input logic [3:0] q);
    return c ? ((q == 4'hf) ? q : q + 4'h1) : 4'h0;
  endfunction

  // busy length, flag length and pin level run counters
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_q <= 8'h00;
      ovr_q  <= 8'h00;
      off_q  <= 4'h0;
      ser_q  <= 4'h0;
      pd_q   <= 4'h0;
    end else begin
      busy_q <= o_busy ? busy_q + 8'h01 : 8'h00;
      ovr_q  <= o_data[11] ? ovr_q + 8'h01 : 8'h00;
      off_q  <= run(i_cs_n | i_rd_n, off_q);
      ser_q  <= run(i_serial_parallel_select & i_serial_clock_source_select, ser_q);
      pd_q   <= run(i_power_down_input, pd_q);
    end
  end

  hold_tracks_busy_a: assert property (o_hold == o_busy)
    else $error("hold differs from busy");
  start_cause_a: assert property ($rose(o_busy) |-> !$past(i_conversion_start_n, 3)
    || !$past(i_conversion_start_n, 4) || !$past(i_conversion_start_n, 5))
    else $error("busy rose without a start");
  pd_blocks_start_a: assert property ($rose(o_busy) |-> pd_q < 4'h8)
    else $error("start taken during power down");
  busy_length_a: assert property ($fell(o_busy) |-> busy_q == 2 * CONV_CYCLES)
    else $error("busy length wrong");
  eoc_timing_a: assert property (!o_eoc_n |-> (o_busy && busy_q == CONV_CYCLES)
    || $fell(o_busy))
    else $error("end of conversion strobe misplaced");
  eoc_at_end_a: assert property ($fell(o_busy) |-> !o_eoc_n ##1 o_eoc_n)
    else $error("no strobe at pair end");
  strobe_gate_a: assert property (off_q >= 4'h8 |-> (o_data_oe & 16'hf7ff) == 16'h0000)
    else $error("bus driven without strobes");
  upper_float_a: assert property (ser_q >= 4'h8 |-> o_data_oe[15:12] == 4'h0)
    else $error("upper bits driven in serial mode");
  flag_driven_a: assert property (ser_q >= 4'h8 |-> o_data_oe[11])
    else $error("flag pin not driven");
  ovr_length_a: assert property (ser_q >= 4'h8 && $fell(o_data[11]) |-> ovr_q == OVR_CYCLES)
    else $error("flag pulse length wrong");
  ovr_start_a: assert property (ser_q >= 4'h8 && $rose(o_data[11])
    |-> $fell(o_busy))
    else $error("flag rose away from pair end");
  reset_idle_a: assert property ($fell(i_reset) |-> !o_busy && o_eoc_n)
    else $error("not idle after reset");
endmodule

bind adc_conversion_output_control adc_ctrl_checker #(
  .CONV_CYCLES(CONV_CYCLES),
  .OVR_CYCLES (OVR_CYCLES)
) adc_ctrl_checker_inst (
  .i_ref_clk                   (i_ref_clk),
  .i_reset                     (i_reset),
  .i_conversion_start_n        (i_conversion_start_n),
  .i_power_down_input          (i_power_down_input),
  .i_serial_parallel_select    (i_serial_parallel_select),
  .i_serial_clock_source_select(i_serial_clock_source_select),
  .i_cs_n                      (i_cs_n),
  .i_rd_n                      (i_rd_n),
  .o_hold                      (o_hold),
  .o_busy                      (o_busy),
  .o_eoc_n                     (o_eoc_n),
  .o_data                      (o_data),
  .o_data_oe                   (o_data_oe)
);
`default_nettype wire

// >>> test/host_serial_reader.sv
// Purpose: host that clocks result frames out of the serial port
// Assumes: 160 ns link clock that only runs inside frames
// Notes:   leading edges with select high let the new pair cross over
`timescale 1ns/1ps
`default_nettype none
module host_serial_reader (
  // link pins
  output logic        o_sclk,
  output logic        o_cs_n,
  input  wire logic   i_sdata,
  // captured frame
  output logic [31:0] o_frame,
  output logic        o_done
);
  initial begin
    o_sclk  = 1'b0;
    o_cs_n  = 1'b1;
    o_frame = 32'h0000_0000;
    o_done  = 1'b0;
  end

  // pre gated edges, then n selected edges; data sampled on the fall
  task automatic frame(input int pre, input int n);
    #3.3;
    for (int k = 0; k < pre + n; k++) begin
      o_cs_n = (k < pre);
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
      if (k >= pre) o_frame = {o_frame[30:0], i_sdata};
    end
    #80 o_cs_n = 1'b1;
    if (n == 32) begin
      o_done = 1'b1;
      #8 o_done = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> test/tb_adc_conversion_output_control.sv
// Purpose: self-checking bench of the converter control block
// Assumes: inputs change on the falling reference edge
// Notes:   core results come from a simple per-channel model
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_output_control;
  logic        clk, rst, start_n, pd, imp, ser, ext, chb, pcs_n, rd_n;
  logic        sclk, hcs_n, chan_b, hold, busy, eoc_n, done;
  logic [15:0] sar, va, vb, data, oe;
  logic [31:0] frame;
  int          fails, checks_done, eocs, n;
  logic [31:0] frame_q[$];
  int          pair_q[$];

  adc_conversion_output_control adc_conversion_output_control_inst (
    .i_ref_clk(clk), .i_reset(rst), .i_conversion_start_n(start_n),
    .i_power_down_input(pd), .i_impulse_mode(imp), .i_serial_parallel_select(ser),
    .i_serial_clock_source_select(ext), .i_read_chan_b(chb), .i_cs_n(pcs_n & hcs_n),
    .i_rd_n(rd_n), .i_sclk_ext(sclk), .i_sar_result(sar), .o_sar_chan_b(chan_b),
    .o_hold(hold), .o_busy(busy), .o_eoc_n(eoc_n), .o_data(data), .o_data_oe(oe));

  host_serial_reader host_serial_reader_inst (
    .o_sclk(sclk), .o_cs_n(hcs_n), .i_sdata(oe[8] ? data[8] : 1'bz),
    .o_frame(frame), .o_done(done));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // core model presents each channel's word while it converts
  always @(negedge clk) sar <= chan_b ? vb : va;

  // strobe counter and result monitors
  always @(negedge clk) if (eoc_n === 1'b0) eocs++;
  always @(negedge busy) begin
    @(posedge clk);
    #1;
    if (!rst && pair_q.size() > 0) chk("eoc count", pair_q.pop_front(), eocs);
    eocs = 0;
  end
  always @(posedge done) chk("serial frame", frame_q.pop_front(), frame);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) begin
      fails++;
      $display("[ERR] busy wait expected %b seen %b", v, busy);
      stop_test();
    end
  endtask

  // one pair with fresh random words; pd may rise mid-pair
  task automatic convert(input logic to_frame, input logic pd_mid);
    va = 16'($urandom);
    vb = 16'($urandom);
    pair_q.push_back(2);
    if (to_frame) frame_q.push_back({va, vb});
    start_n = 1'b0;
    cyc(8);
    start_n = 1'b1;
    wait_busy(1'b1);
    pd = pd_mid;
    wait_busy(1'b0);
  endtask

  task automatic par_read(input logic ch, input logic [15:0] exp);
    chb = ch;
    pcs_n = 1'b0;
    rd_n = 1'b0;
    cyc(8);
    chk("parallel word", 32'(exp), 32'(data));
    chk("parallel enable", 32'hffff, 32'(oe));
    pcs_n = 1'b1;
    rd_n = 1'b1;
    cyc(8);
    chk("released enable", 32'h0, 32'(oe));
  endtask

  initial begin
    {start_n, pcs_n, rd_n, rst} = 4'hf;
    {pd, imp, ser, ext, chb} = 5'h0;
    va = 16'h0000;
    vb = 16'h0000;
    sar = 16'h0000;
    fails = 0;
    checks_done = 0;
    eocs = 0;
    void'($urandom(32'h7fb96832));
    cyc(4);
    rst = 1'b0;
    pcs_n = 1'b0;
    rd_n = 1'b0;
    cyc(8);
    chk("enable before result", 32'h0, 32'(oe));
    {pcs_n, rd_n} = 2'b11;
    convert(1'b0, 1'b0);
    par_read(1'b0, va);
    par_read(1'b1, vb);
    convert(1'b0, 1'b1);
    start_n = 1'b0;
    cyc(8);
    start_n = 1'b1;
    cyc(60);
    chk("busy in power down", 32'h0, 32'(busy));
    pd = 1'b0;
    imp = 1'b1;
    pair_q.push_back(2);
    pair_q.push_back(2);
    start_n = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("burst restart", 32'h1, 32'(n <= adc_ctrl_pkg::ACQ_CYCLES + 8));
    start_n = 1'b1;
    wait_busy(1'b0);
    imp = 1'b0;
    {ser, ext, rd_n} = 3'b110;
    cyc(40);
    chk("upper enables", 32'h0, 32'(oe[15:12]));
    chk("flag enable", 32'h1, 32'(oe[11]));
    convert(1'b1, 1'b0);
    host_serial_reader_inst.frame(8, 32);
    convert(1'b0, 1'b0);
    host_serial_reader_inst.frame(8, 10);
    convert(1'b1, 1'b0);
    cyc(2);
    chk("overrun flag", 32'h1, 32'(data[11]));
    host_serial_reader_inst.frame(8, 32);
    {ser, ext, rd_n} = 3'b001;
    cyc(40);
    start_n = 1'b0;
    cyc(8);
    start_n = 1'b1;
    wait_busy(1'b1);
    cyc(20);
    rst = 1'b1;
    cyc(2);
    chk("busy on reset", 32'h0, 32'(busy));
    rst = 1'b0;
    cyc(8);
    stop_test();
  end
endmodule
`default_nettype wire
